// [shared/cmod_defs.vh]
// cmod_defs.vh: addresses, field positions and word values of the cmod block
// assumes: included by the rtl files of the cmod block, definitions only
`ifndef CMOD_DEFS_VH
`define CMOD_DEFS_VH

// ------------------------------------------------------------
// configuration space addresses
// ------------------------------------------------------------
`define CMOD_ADDR_UID0     16'h8000
`define CMOD_ADDR_UID3     16'h8003
`define CMOD_ADDR_PARTID   16'h8006
`define CMOD_ADDR_OPT1     16'h8007
`define CMOD_ADDR_OPT2     16'h8008
`define CMOD_ADDR_CAL0     16'h8009
`define CMOD_ADDR_CAL1     16'h800a
`define CMOD_ADDR_ZERO     16'h0000

// ------------------------------------------------------------
// word values
// ------------------------------------------------------------
`define CMOD_WORD_BLANK    14'h3fff
`define CMOD_WORD_ZERO     14'h0000
`define CMOD_OPT2_UNIMPL   14'h00dc

// ------------------------------------------------------------
// option word one field positions
// ------------------------------------------------------------
`define CMOD_W1_OSC_LSB    0
`define CMOD_W1_PWRT       5
`define CMOD_W1_RSTPIN     6
`define CMOD_W1_PROT       7
`define CMOD_W1_DPROT      8
`define CMOD_W1_BOR_LSB    9

// ------------------------------------------------------------
// option word two field positions
// ------------------------------------------------------------
`define CMOD_W2_WP_LSB     0
`define CMOD_W2_VCAP       5
`define CMOD_W2_STACK      9
`define CMOD_W2_BORTRIP    10
`define CMOD_W2_LOW_POWER_BROWNOUT_DISABLE      11
`define CMOD_W2_LVE        13

// ------------------------------------------------------------
// self-write protect range codes
// ------------------------------------------------------------
`define CMOD_WP_OFF        2'b11
`define CMOD_WP_BOOT       2'b10
`define CMOD_WP_HALF       2'b01
`define CMOD_WP_BOOT_TOP   13'h01ff

`endif

// [rtl/cmod_addr_ptr.v]
// cmod_addr_ptr: internal address pointer of the programming session
// assumes: command pulses are one cycle wide and, but for enter, only arrive during a session
`include "cmod_defs.vh"
`default_nettype none

module cmod_addr_ptr (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // pointer commands
  input  wire        enter,
  input  wire        load_cfg,
  input  wire        incr,
  input  wire        reset_addr,
  // pointer value
  output reg  [15:0] addr_ff
);

  // ------------------------------------------------------------
  // pointer update, entry has priority over any command
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      addr_ff <= `CMOD_ADDR_ZERO;
    end else if (enter || reset_addr) begin
      addr_ff <= `CMOD_ADDR_ZERO;
    end else if (load_cfg) begin
      addr_ff <= `CMOD_ADDR_UID0;
    end else if (incr) begin
      addr_ff <= addr_ff + 16'h0001;
    end
  end

endmodule // cmod_addr_ptr
`default_nettype wire

// [rtl/cmod_option_decode.v]
// cmod_option_decode: combinational decode of the two option words
// assumes: words arrive with unimplemented bits already forced high
`include "cmod_defs.vh"
`default_nettype none

module cmod_option_decode #(
  parameter PMEM_AW = 13
) (
  // stored option words
  input  wire [13:0] opt1,
  input  wire [13:0] opt2,
  // decoded controls
  output wire [2:0]  osc_select,
  output wire        lv_entry_en,
  output wire        rst_pin_is_reset,
  output wire        prog_protect_on,
  output wire        data_protect_on,
  output wire        pwrt_on,
  output wire [1:0]  bor_mode,
  output wire        stack_reset_en,
  output wire        low_power_brownout_disable_off,
  output wire        bor_low_trip,
  output wire        vcore_pad_on,
  output wire        wp_on,
  output wire [12:0] wp_top
);

  wire [1:0] wp_code;
  wire [12:0] mem_top;

  // ------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------
  assign osc_select      = opt1[`CMOD_W1_OSC_LSB +: 3];
  assign lv_entry_en     = opt2[`CMOD_W2_LVE];
  // low-voltage entry forces the pin to act as reset
  assign rst_pin_is_reset = lv_entry_en | opt1[`CMOD_W1_RSTPIN];
  assign prog_protect_on = ~opt1[`CMOD_W1_PROT];
  assign data_protect_on = ~opt1[`CMOD_W1_DPROT];
  // timer and brown-out each follow their own field only
  assign pwrt_on         = ~opt1[`CMOD_W1_PWRT];
  assign bor_mode        = opt1[`CMOD_W1_BOR_LSB +: 2];
  assign stack_reset_en  = opt2[`CMOD_W2_STACK];
  assign low_power_brownout_disable_off       = opt2[`CMOD_W2_LOW_POWER_BROWNOUT_DISABLE];
  assign bor_low_trip    = opt2[`CMOD_W2_BORTRIP];
  assign vcore_pad_on    = ~opt2[`CMOD_W2_VCAP];

  // ------------------------------------------------------------
  // self-write protect range, half and full tops scale with memory size, boot top fixed at 01ffh
  // ------------------------------------------------------------
  assign wp_code = opt2[`CMOD_W2_WP_LSB +: 2];
  assign mem_top = 13'h1fff >> (13 - PMEM_AW);
  assign wp_on   = (wp_code != `CMOD_WP_OFF);
  assign wp_top  = (wp_code == `CMOD_WP_BOOT) ? `CMOD_WP_BOOT_TOP :
                   (wp_code == `CMOD_WP_HALF) ? (mem_top >> 1) : mem_top;

endmodule // cmod_option_decode
`default_nettype wire

// [rtl/cmod_config_mem.v]
// Functional notes
// - four 14-bit user words at 8000h-8003h, readable regardless of protection
// - part identity word at 8006h is fixed, erase and write leave it alone
// - identity word holds part identifier above, silicon revision in low 5 bits
// - two option words sit at 8007h and 8008h
// - calibration words never take part in any erase
// - low-voltage entry bit starts at one, cleared only in high-voltage session
// - low-voltage entry bit zero refuses low-voltage entry
// - high-voltage entry accepted on elevated reset pin level unless session_exit is high at that edge
// - low-voltage enabled makes reset pin a reset, no general input use
// - erasing data protection off also erases all data memory
// - turning program protection off erases all program memory
// - 3-bit oscillator field selects clock source
// - stack reset bit one makes stack overflow or underflow reset device
// - low-power brown-out bit one keeps that detector off
// - brown-out trip bit one low point, zero high point
// - regulator cap bit one disconnects core supply pad, zero connects
// - 2-bit self-write field: off, low 200h, lower half, all
// - half and full protect boundaries scale with program memory size, boot boundary fixed at 01ffh
// - brown-out reset and power-up timer each follow only their field
// - entry clears address, load configuration sets 8000h
//
// cmod_config_mem: configuration words reached from the programming port
// assumes: command strobes are one-cycle pulses already decoded from the serial port
`include "cmod_defs.vh"
`default_nettype none

module cmod_config_mem #(
  parameter        PMEM_AW   = 13,
  parameter [8:0]  PART_ID   = 9'h0c3,     // arbitrary neutral value
  parameter [4:0]  SILI_REV  = 5'h01,      // arbitrary neutral value
  parameter [13:0] CAL_WORD0 = 14'h2a55,
  parameter [13:0] CAL_WORD1 = 14'h1234,
  parameter [13:0] INIT_UID  = 14'h3fff,
  parameter [13:0] INIT_OPT1 = 14'h3fff,
  parameter [13:0] INIT_OPT2 = 14'h3fff
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // session entry and exit
  input  wire        high_voltage_entry_level,
  input  wire        lv_key_valid,
  input  wire        session_exit,
  // programming commands
  input  wire        cmd_load_cfg,
  input  wire        cmd_load_data,
  input  wire        cmd_incr_addr,
  input  wire        cmd_reset_addr,
  input  wire        cmd_prog_int,
  input  wire        cmd_prog_ext,
  input  wire        cmd_erase_prog,
  input  wire        cmd_erase_data,
  input  wire        cmd_read,
  input  wire [13:0] wr_data,
  // programming answers
  output reg  [13:0] rd_data_ff,
  output reg         rd_valid_ff,
  output reg         cmd_done_ff,
  output reg  [15:0] addr_out_ff,
  output reg         hv_session_ff,
  output reg         lv_session_ff,
  output reg         lv_refused_ff,
  // erase requests to the memory arrays
  output reg         prog_mem_erase_ff,
  output reg         data_mem_erase_ff,
  // device controls
  input  wire        stack_fault,
  output reg         stack_reset_req_ff,
  output reg  [2:0]  osc_select_ff,
  output reg         low_voltage_entry_enable_ff,
  output reg         master_reset_pin_is_reset_ff,
  output reg         program_read_protect_ff,
  output reg         data_read_protect_ff,
  output reg         powerup_timer_enable_ff,
  output reg  [1:0]  brownout_reset_mode_ff,
  output reg         stack_fault_reset_enable_ff,
  output reg         low_power_brownout_disable_ff,
  output reg         brownout_trip_select_ff,
  output reg         vcore_pad_connect_ff,
  output reg         self_write_protect_on_ff,
  output reg  [12:0] self_write_protect_top_ff
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  localparam [2:0] SEL_NONE = 3'd0;
  localparam [2:0] SEL_UID  = 3'd1;
  localparam [2:0] SEL_PID  = 3'd2;
  localparam [2:0] SEL_OPT1 = 3'd3;
  localparam [2:0] SEL_OPT2 = 3'd4;
  localparam [2:0] SEL_CAL0 = 3'd5;
  localparam [2:0] SEL_CAL1 = 3'd6;

  // map a pointer value onto the word it selects
  function [2:0] word_sel;
    input [15:0] a;
    begin
      if (a >= `CMOD_ADDR_UID0 && a <= `CMOD_ADDR_UID3) begin
        word_sel = SEL_UID;
      end else if (a == `CMOD_ADDR_PARTID) begin
        word_sel = SEL_PID;
      end else if (a == `CMOD_ADDR_OPT1) begin
        word_sel = SEL_OPT1;
      end else if (a == `CMOD_ADDR_OPT2) begin
        word_sel = SEL_OPT2;
      end else if (a == `CMOD_ADDR_CAL0) begin
        word_sel = SEL_CAL0;
      end else if (a == `CMOD_ADDR_CAL1) begin
        word_sel = SEL_CAL1;
      end else begin
        word_sel = SEL_NONE;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // storage and internal signals
  // ------------------------------------------------------------
  reg  [13:0] uid_ff [0:3];
  reg  [13:0] opt1_ff;
  reg  [13:0] opt2_ff;
  reg  [13:0] latch_ff;
  reg  [13:0] nxt_opt2;
  reg  [13:0] nxt_rd;
  wire [15:0] addr;
  wire [2:0]  sel;
  wire [1:0]  uid_idx;
  wire        in_session;
  wire        enter;
  wire        cfg_space;
  wire [13:0] part_word;
  integer     i;

  // decoded option fields
  wire [2:0]  dec_osc;
  wire        dec_lve;
  wire        dec_rst_pin;
  wire        dec_prot;
  wire        dec_dprot;
  wire        dec_pwrt;
  wire [1:0]  dec_bor;
  wire        dec_stack;
  wire        dec_low_power_brownout_disable;
  wire        dec_trip;
  wire        dec_vcore;
  wire        dec_wp_on;
  wire [12:0] dec_wp_top;

  assign sel        = word_sel(addr);
  assign uid_idx    = addr[1:0];
  assign in_session = hv_session_ff | lv_session_ff;
  assign cfg_space  = addr >= `CMOD_ADDR_UID0;
  // identity word is built from parameters only, no storage can alter it
  assign part_word  = {PART_ID, SILI_REV};

  // ------------------------------------------------------------
  // session entry
  // ------------------------------------------------------------
  // high voltage wins over the stored entry bit; a key counts only while it reads one
  assign enter = !in_session && !session_exit &&
                 (high_voltage_entry_level || (lv_key_valid && dec_lve));

  always @(posedge mclk) begin
    if (!rst_n) begin
      hv_session_ff <= 1'b0;
      lv_session_ff <= 1'b0;
      lv_refused_ff <= 1'b0;
    end else begin
      lv_refused_ff <= 1'b0;
      if (session_exit) begin
        hv_session_ff <= 1'b0;
        lv_session_ff <= 1'b0;
      end else if (!in_session && high_voltage_entry_level) begin
        hv_session_ff <= 1'b1;
      end else if (!in_session && lv_key_valid) begin
        lv_session_ff <= dec_lve;
        lv_refused_ff <= ~dec_lve;
      end
    end
  end

  // ------------------------------------------------------------
  // address pointer
  // ------------------------------------------------------------
  cmod_addr_ptr u_ptr (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .enter      (enter),
    .load_cfg   (cmd_load_cfg & in_session),
    .incr       (cmd_incr_addr & in_session),
    .reset_addr (cmd_reset_addr & in_session),
    .addr_ff    (addr)
  );

  // ------------------------------------------------------------
  // option word two write value
  // ------------------------------------------------------------
  // unimplemented bits stay high; the entry bit drops only in a high-voltage session
  always @* begin
    nxt_opt2 = latch_ff | `CMOD_OPT2_UNIMPL;
    if (!hv_session_ff) begin
      nxt_opt2[`CMOD_W2_LVE] = opt2_ff[`CMOD_W2_LVE];
    end
  end

  // ------------------------------------------------------------
  // stored words: load, program and erase
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        uid_ff[i] <= INIT_UID;
      end
      opt1_ff  <= INIT_OPT1;
      opt2_ff  <= INIT_OPT2 | `CMOD_OPT2_UNIMPL;
      latch_ff <= `CMOD_WORD_BLANK;
    end else if (in_session) begin
      if (cmd_load_cfg || cmd_load_data) begin
        latch_ff <= wr_data;
      end
      if (cmd_prog_int || cmd_prog_ext) begin
        case (sel)
          SEL_UID: uid_ff[uid_idx] <= latch_ff;
          // option words ignore externally timed programming
          SEL_OPT1: begin
            if (cmd_prog_int) begin
              opt1_ff <= latch_ff;
            end
          end
          SEL_OPT2: begin
            if (cmd_prog_int) begin
              opt2_ff <= nxt_opt2;
            end
          end
          // identity, calibration and unmapped words are accepted and dropped
          default: begin
            latch_ff <= latch_ff;
          end
        endcase
      end else if (cmd_erase_prog && cfg_space) begin
        // bulk erase blanks user and option words; calibration and identity stay
        for (i = 0; i < 4; i = i + 1) begin
          uid_ff[i] <= `CMOD_WORD_BLANK;
        end
        opt1_ff <= `CMOD_WORD_BLANK;
        opt2_ff <= `CMOD_WORD_BLANK;
      end
    end
  end

  // ------------------------------------------------------------
  // erase side effects on the memory arrays
  // ------------------------------------------------------------
  // erase that lifts protection wipes the protected array too, so secrets never leak
  always @(posedge mclk) begin
    if (!rst_n) begin
      prog_mem_erase_ff <= 1'b0;
      data_mem_erase_ff <= 1'b0;
    end else begin
      prog_mem_erase_ff <= in_session && cmd_erase_prog;
      data_mem_erase_ff <= in_session && (cmd_erase_data ||
                           (cmd_erase_prog && cfg_space && dec_dprot));
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // user words ignore protection; addresses outside the block read zero
  always @* begin
    case (sel)
      SEL_UID:  nxt_rd = uid_ff[uid_idx];
      SEL_PID:  nxt_rd = part_word;
      SEL_OPT1: nxt_rd = opt1_ff;
      SEL_OPT2: nxt_rd = opt2_ff | `CMOD_OPT2_UNIMPL;
      SEL_CAL0: nxt_rd = CAL_WORD0;
      SEL_CAL1: nxt_rd = CAL_WORD1;
      default:  nxt_rd = `CMOD_WORD_ZERO;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      rd_data_ff  <= `CMOD_WORD_ZERO;
      rd_valid_ff <= 1'b0;
      cmd_done_ff <= 1'b0;
      addr_out_ff <= `CMOD_ADDR_ZERO;
    end else begin
      rd_valid_ff <= in_session && cmd_read;
      if (in_session && cmd_read) begin
        rd_data_ff <= nxt_rd;
      end
      // every program or erase finishes cleanly, even when dropped
      cmd_done_ff <= in_session && (cmd_prog_int || cmd_prog_ext ||
                     cmd_erase_prog || cmd_erase_data);
      addr_out_ff <= addr;
    end
  end

  // ------------------------------------------------------------
  // option decode
  // ------------------------------------------------------------
  cmod_option_decode #(
    .PMEM_AW (PMEM_AW)
  ) u_dec (
    .opt1             (opt1_ff),
    .opt2             (opt2_ff),
    .osc_select       (dec_osc),
    .lv_entry_en      (dec_lve),
    .rst_pin_is_reset (dec_rst_pin),
    .prog_protect_on  (dec_prot),
    .data_protect_on  (dec_dprot),
    .pwrt_on          (dec_pwrt),
    .bor_mode         (dec_bor),
    .stack_reset_en   (dec_stack),
    .low_power_brownout_disable_off        (dec_low_power_brownout_disable),
    .bor_low_trip     (dec_trip),
    .vcore_pad_on     (dec_vcore),
    .wp_on            (dec_wp_on),
    .wp_top           (dec_wp_top)
  );

  // ------------------------------------------------------------
  // static control outputs
  // ------------------------------------------------------------
  // registered for glitch-free levels; they follow a store one cycle late
  always @(posedge mclk) begin
    if (!rst_n) begin
      osc_select_ff                 <= 3'h7;
      low_voltage_entry_enable_ff   <= 1'b1;
      master_reset_pin_is_reset_ff  <= 1'b1;
      program_read_protect_ff       <= 1'b0;
      data_read_protect_ff          <= 1'b0;
      powerup_timer_enable_ff       <= 1'b0;
      brownout_reset_mode_ff        <= 2'h3;
      stack_fault_reset_enable_ff   <= 1'b1;
      low_power_brownout_disable_ff <= 1'b1;
      brownout_trip_select_ff       <= 1'b1;
      vcore_pad_connect_ff          <= 1'b0;
      self_write_protect_on_ff      <= 1'b0;
      self_write_protect_top_ff     <= 13'h0000;
      stack_reset_req_ff            <= 1'b0;
    end else begin
      osc_select_ff                 <= dec_osc;
      low_voltage_entry_enable_ff   <= dec_lve;
      master_reset_pin_is_reset_ff  <= dec_rst_pin;
      program_read_protect_ff       <= dec_prot;
      data_read_protect_ff          <= dec_dprot;
      powerup_timer_enable_ff       <= dec_pwrt;
      brownout_reset_mode_ff        <= dec_bor;
      stack_fault_reset_enable_ff   <= dec_stack;
      low_power_brownout_disable_ff <= dec_low_power_brownout_disable;
      brownout_trip_select_ff       <= dec_trip;
      vcore_pad_connect_ff          <= dec_vcore;
      self_write_protect_on_ff      <= dec_wp_on;
      self_write_protect_top_ff     <= dec_wp_top;
      stack_reset_req_ff            <= stack_fault && dec_stack;
    end
  end

endmodule // cmod_config_mem
`default_nettype wire

// [tb/cmod_config_mem_sva.sv]
// cmod_config_mem_sva: timing checks at the ports of cmod_config_mem
// assumes: bound inside the design, one mclk domain, sync reset rst_n
`default_nettype none
module cmod_config_mem_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // programming port
  input wire logic high_voltage_entry_level,
  input wire logic lv_key_valid,
  input wire logic session_exit,
  input wire logic cmd_read,
  input wire logic cmd_prog_int,
  input wire logic cmd_erase_prog,
  input wire logic rd_valid_ff,
  input wire logic cmd_done_ff,
  input wire logic hv_session_ff,
  input wire logic lv_session_ff,
  input wire logic lv_refused_ff,
  input wire logic prog_mem_erase_ff,
  // device controls
  input wire logic stack_fault,
  input wire logic stack_reset_req_ff,
  input wire logic stack_fault_reset_enable_ff,
  input wire logic low_voltage_entry_enable_ff,
  input wire logic master_reset_pin_is_reset_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // properties
  // ------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire in_sess = hv_session_ff || lv_session_ff;
  sequence s_read; cmd_read && in_sess; endsequence
  sequence s_prog; cmd_prog_int && in_sess; endsequence
  sequence s_erase; cmd_erase_prog && in_sess; endsequence
  // refused only when no high-voltage entry competes at that edge
  sequence s_bad_key;
    lv_key_valid && !low_voltage_entry_enable_ff && !high_voltage_entry_level && !in_sess;
  endsequence
  sequence s_fault; stack_fault ##1 1'b1; endsequence
  AST_READ_ANSWER: assert property (s_read |=> rd_valid_ff) else $error("read not answered");
  AST_PROG_DONE: assert property (s_prog |=> cmd_done_ff) else $error("write not done");
  AST_ERASE_REQ: assert property (s_erase |=> prog_mem_erase_ff) else $error("no erase request");
  AST_KEY_REFUSED: assert property (s_bad_key |=> lv_refused_ff && !lv_session_ff) else $error("key taken");
  AST_HV_ENTRY: assert property (high_voltage_entry_level && !session_exit |=> hv_session_ff)
    else $error("hv entry lost");
  AST_RST_PIN: assert property (low_voltage_entry_enable_ff |-> master_reset_pin_is_reset_ff)
    else $error("reset pin freed");
  AST_LVE_CLEAR: assert property ($fell(low_voltage_entry_enable_ff) |->
    $past(hv_session_ff) || $past(hv_session_ff, 2)) else $error("entry bit cleared outside hv");
  AST_STACK_RESET: assert property (s_fault |-> stack_reset_req_ff == stack_fault_reset_enable_ff)
    else $error("stack reset wrong");
endmodule // cmod_config_mem_sva
`default_nettype wire

// [tb/cmod_prog_model.sv]
// cmod_prog_model: programmer model, already reduced to one-cycle command strobes
// assumes: strobes are taken on rising mclk, so every change here follows a falling edge
`default_nettype none
module cmod_prog_model (
  // clock
  input  wire logic        mclk,
  // entry and exit
  output var  logic        high_voltage_entry_level,
  output var  logic        lv_key_valid,
  output var  logic        session_exit,
  // strobes and data word
  output var  logic [8:0]  cmd,
  output var  logic [13:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // idle levels and tasks
  // ------
  initial begin
    high_voltage_entry_level = 1'b0;
    lv_key_valid = 1'b0;
    session_exit = 1'b0;
    cmd = 9'h000;
    wr_data = 14'h0000;
  end
  // random gap varies host pace; the released word is inverted, never stale
  task automatic strobe(input int k, input logic [13:0] d = 14'h0000);
    repeat ($urandom_range(2)) @(negedge mclk);
    @(negedge mclk);
    cmd <= 9'h001 << k;
    wr_data <= d;
    @(negedge mclk);
    cmd <= 9'h000;
    wr_data <= ~d;
  endtask
  // entry raises the level; exit drops it with a one-cycle release pulse
  task automatic session(input logic on);
    @(negedge mclk);
    high_voltage_entry_level <= on;
    session_exit <= ~on;
    @(negedge mclk);
    session_exit <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic key;
    @(negedge mclk);
    lv_key_valid <= 1'b1;
    @(negedge mclk);
    lv_key_valid <= 1'b0;
  endtask
endmodule // cmod_prog_model
`default_nettype wire

// [tb/cmod_config_mem_bench.sv]
// cmod_config_mem_bench: self-checking bench of the configuration memory
// assumes: cmod_prog_model drives the strobes, the checker is bound below
`include "cmod_defs.vh"
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module cmod_config_mem_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LCFG = 0, LDAT = 1, INCR = 2, PINT = 4, EPRG = 6, READ = 8;
  localparam logic [8:0]  PART = 9'h0c3;   // arbitrary value
  localparam logic [4:0]  REVI = 5'h01;    // arbitrary value
  localparam logic [13:0] CAL0 = 14'h2a55;
  logic        mclk = 1'b0, rst_n = 1'b0, stack_fault = 1'b0;
  logic        high_voltage_entry_level, lv_key_valid, session_exit, rd_valid_ff, cmd_done_ff;
  logic        hv_session_ff, lv_session_ff, lv_refused_ff, prog_mem_erase_ff, stack_reset_req_ff;
  logic        low_voltage_entry_enable_ff, master_reset_pin_is_reset_ff, stack_fault_reset_enable_ff;
  logic        low_power_brownout_disable_ff, brownout_trip_select_ff, vcore_pad_connect_ff, data_mem_erase_ff;
  logic        self_write_protect_on_ff, program_read_protect_ff, data_read_protect_ff, powerup_timer_enable_ff;
  logic [1:0]  brownout_reset_mode_ff;
  logic [2:0]  osc_select_ff;
  logic [8:0]  cmd;
  logic [12:0] self_write_protect_top_ff;
  logic [13:0] wr_data, rd_data_ff, w, w1, w2, e;
  logic [15:0] addr_out_ff;
  logic [13:0] q[$];
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  // ------
  // instances, clock and watchers
  // ------
  cmod_prog_model prog (.mclk, .high_voltage_entry_level, .lv_key_valid, .session_exit, .cmd, .wr_data);
  cmod_config_mem #(.PART_ID(PART), .SILI_REV(REVI), .CAL_WORD0(CAL0)) i_cmod_config_mem (
    .mclk, .rst_n, .high_voltage_entry_level, .lv_key_valid, .session_exit, .cmd_load_cfg(cmd[0]),
    .cmd_load_data(cmd[1]), .cmd_incr_addr(cmd[2]), .cmd_reset_addr(cmd[3]), .cmd_prog_int(cmd[4]),
    .cmd_prog_ext(cmd[5]), .cmd_erase_prog(cmd[6]), .cmd_erase_data(cmd[7]), .cmd_read(cmd[8]),
    .wr_data, .rd_data_ff, .rd_valid_ff, .cmd_done_ff, .addr_out_ff, .hv_session_ff, .lv_session_ff,
    .lv_refused_ff, .prog_mem_erase_ff, .data_mem_erase_ff, .stack_fault, .stack_reset_req_ff,
    .osc_select_ff, .low_voltage_entry_enable_ff, .master_reset_pin_is_reset_ff, .program_read_protect_ff,
    .data_read_protect_ff, .powerup_timer_enable_ff, .brownout_reset_mode_ff, .stack_fault_reset_enable_ff,
    .low_power_brownout_disable_ff, .brownout_trip_select_ff, .vcore_pad_connect_ff, .self_write_protect_on_ff,
    .self_write_protect_top_ff);
  always #20 mclk = ~mclk;
  // random faults so the stack reset path sees both fault levels
  always @(negedge mclk) stack_fault <= 1'($urandom);
  // oldest note per answer; an answer nobody asked for never matches
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      stop_test();
    end
    if (rd_valid_ff === 1'b1) begin
      e = (q.size() != 0) ? q.pop_front() : ~rd_data_ff;
      `CHK("rd_data", e, rd_data_ff);
    end
    if (prog_mem_erase_ff === 1'b1) `CHK("dmem_erase", ~w1[8], data_mem_erase_ff);
  end
  task automatic wr(input logic [13:0] d);
    prog.strobe(LDAT, d);
    prog.strobe(PINT);
  endtask
  task automatic rd(input logic [13:0] x);
    q.push_back(x);
    prog.strobe(READ);
  endtask
  task automatic step(input int n);
    repeat (n) prog.strobe(INCR);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    void'($urandom(97545));
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst_n <= 1'b1;
    prog.session(1'b1);
    `CHK("hv_session", 1'b1, hv_session_ff);
    prog.strobe(LCFG);
    @(negedge mclk);
    `CHK("addr_out", 16'h8000, addr_out_ff);
    for (int i = 0; i < 4; i++) begin
      w = 14'($urandom);
      wr(w);
      rd(w);
      step(1);
    end
    step(2);
    wr(14'($urandom));
    rd({PART, REVI});
    step(1);
    w1 = 14'($urandom);
    wr(w1);
    rd(w1);
    step(1);
    w2 = 14'($urandom) & 14'h1fff;
    wr(w2);
    rd(w2 | `CMOD_OPT2_UNIMPL);
    repeat (3) @(negedge mclk);
    `CHK("lve", 1'b0, low_voltage_entry_enable_ff);
    `CHK("rst_pin", w1[6], master_reset_pin_is_reset_ff);
    `CHK("osc", w1[2:0], osc_select_ff);
    `CHK("protect", ~w1[8:7], {data_read_protect_ff, program_read_protect_ff});
    `CHK("pwrt_bor", {~w1[5], w1[10:9]}, {powerup_timer_enable_ff, brownout_reset_mode_ff});
    `CHK("stack_en", w2[9], stack_fault_reset_enable_ff);
    `CHK("low_power_brownout_disable", w2[11], low_power_brownout_disable_ff);
    `CHK("trip", w2[10], brownout_trip_select_ff);
    `CHK("vcore", ~w2[5], vcore_pad_connect_ff);
    `CHK("wp_on", w2[1:0] != 2'b11, self_write_protect_on_ff);
    if (w2[1:0] != 2'b11)
      `CHK("wp_top", w2[1] ? 13'h01ff : (w2[0] ? 13'h0fff : 13'h1fff), self_write_protect_top_ff);
    prog.session(1'b0);
    prog.strobe(READ); // outside a session: no answer
    prog.key();
    @(negedge mclk);
    `CHK("lv_session", 1'b0, lv_session_ff);
    prog.session(1'b1);
    `CHK("hv_again", 1'b1, hv_session_ff);
    prog.strobe(LCFG);
    prog.strobe(EPRG);
    rd(`CMOD_WORD_BLANK);
    step(9);
    rd(CAL0);
    repeat (4) @(negedge mclk);
    `CHK("pending", 0, q.size());
    stop_test();
  end
endmodule // cmod_config_mem_bench
bind cmod_config_mem cmod_config_mem_sva i_cmod_config_mem_sva (.mclk, .rst_n, .high_voltage_entry_level,
  .lv_key_valid, .session_exit, .cmd_read, .cmd_prog_int, .cmd_erase_prog, .rd_valid_ff, .cmd_done_ff,
  .hv_session_ff, .lv_session_ff, .lv_refused_ff, .prog_mem_erase_ff, .stack_fault, .stack_reset_req_ff,
  .stack_fault_reset_enable_ff, .low_voltage_entry_enable_ff, .master_reset_pin_is_reset_ff);
`default_nettype wire
